// >>> dgb_control.sv
// gain, auxiliary converter and clock-multiplier band control with its register file
// assumes registers come over the serial port; samples arrive offset binary on CLK_SYS
//
// How it works
// R1: host writes 63 into band to search
// R2: device raises lock bit; host waits for it
// R3: host corrects lower bands by start-up temperature
// R4: host corrects upper bands by start-up temperature
// R5: host writes corrected band back into bits 7:2
// R6: host may reload a stored band at power-up
// R7: each main channel gain from own 10-bit word
// R8: digital amplitude scaling from scale register
// R9: scaling keeps midscale, scales only the excursion
// R10: auxiliary magnitude from bits 9:0
// R11: bit 15 picks driven side, other high impedance
// R12: bit 14 picks source or sink
// R13: host clamps corrected band to valid range
`timescale 1ns/1ns
module dgb_control #(
  parameter int unsigned DW = 16,
  parameter int unsigned LOCK_TIMEOUT_CYC = dgb_pkg::LOCK_CYC
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic PLL_LOCK_IN,
  input wire logic [5:0] AUTO_BAND,
  output logic [5:0] PLL_BAND,
  output logic PLL_AUTO,
  output logic PLL_LOCK,
  input wire logic [DW-1:0] SAMPLE_A,
  input wire logic [DW-1:0] SAMPLE_B,
  output logic [DW-1:0] SCALED_A,
  output logic [DW-1:0] SCALED_B,
  output logic [9:0] MAIN_GAIN_A,
  output logic [9:0] MAIN_GAIN_B,
  output dgb_pkg::dgb_aux_s AUX_ONE,
  output dgb_pkg::dgb_aux_s AUX_TWO
);

  if (DW < 2 || DW > 16) begin : g_bad_dw
    $error("DW must lie in 2..16");
  end
  if (LOCK_TIMEOUT_CYC < 1 || LOCK_TIMEOUT_CYC > 32'hFFFFFF) begin : g_bad_tmo
    $error("LOCK_TIMEOUT_CYC out of range");
  end

  // ----------------------------------------
  // serial port
  // ----------------------------------------
  dgb_pkg::dgb_req_s req;
  logic [4:0] raddr;
  logic [15:0] rdata;

  dgb_spi_port u_spi (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .sclk_pin(SCLK),
    .cs_n_pin(CS_N),
    .sdi_pin(SDI),
    .rdata(rdata),
    .sdo(SDO),
    .sdo_oe(SDO_OE),
    .req(req),
    .raddr(raddr)
  );

  // ----------------------------------------
  // lock and found-band synchronisers
  // ----------------------------------------
  logic [6:0] ls1_r, ls2_r, ls3_r, lf_r, lf_nxt;
  logic [15:0] lfilt;

  always_comb begin
    lfilt = dgb_pkg::sync_filt({9'h000, lf_r}, {9'h000, ls2_r}, {9'h000, ls3_r});
    lf_nxt = lfilt[6:0];
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ls1_r <= 7'h00;
      ls2_r <= 7'h00;
      ls3_r <= 7'h00;
      lf_r <= 7'h00;
    end else begin
      ls1_r <= {PLL_LOCK_IN, AUTO_BAND};
      ls2_r <= ls1_r;
      ls3_r <= ls2_r;
      lf_r <= lf_nxt;
    end
  end

  logic lock_f;
  logic [5:0] band_f;
  assign lock_f = lf_r[6];
  assign band_f = lf_r[5:0];

  // ----------------------------------------
  // registers and band search
  // ----------------------------------------
  logic [15:0] pll_r, pll_nxt, aux1_r, aux1_nxt, aux2_r, aux2_nxt;
  logic [9:0] ga_r, ga_nxt, gb_r, gb_nxt;
  logic [13:0] asf_r, asf_nxt;
  logic tmo_r, tmo_nxt;
  logic [23:0] tcnt_r, tcnt_nxt;
  dgb_pkg::dgb_band_e bs_r, bs_nxt;
  logic wr_pll;

  assign wr_pll = req.wr && req.addr == dgb_pkg::OFS_PLL_CTRL;

  always_comb begin
    pll_nxt = pll_r;
    aux1_nxt = aux1_r;
    aux2_nxt = aux2_r;
    ga_nxt = ga_r;
    gb_nxt = gb_r;
    asf_nxt = asf_r;
    tmo_nxt = tmo_r;
    tcnt_nxt = tcnt_r;
    bs_nxt = bs_r;
    if (req.wr) begin
      case (req.addr)
        dgb_pkg::OFS_PLL_CTRL: pll_nxt = req.wdata;
        dgb_pkg::OFS_GAIN_A: ga_nxt = req.wdata[9:0]; // R7
        dgb_pkg::OFS_GAIN_B: gb_nxt = req.wdata[9:0]; // R7
        dgb_pkg::OFS_AUX_ONE: aux1_nxt = req.wdata;
        dgb_pkg::OFS_AUX_TWO: aux2_nxt = req.wdata;
        dgb_pkg::OFS_AMP_SCALE: asf_nxt = req.wdata[13:0]; // R8
        default: ;
      endcase
    end
    case (bs_r)
      dgb_pkg::BS_IDLE, dgb_pkg::BS_LOCKED: begin
        if (wr_pll && req.wdata[dgb_pkg::BAND_LSB +: dgb_pkg::BAND_W] == dgb_pkg::BAND_AUTO) begin // R1
          bs_nxt = dgb_pkg::BS_SEARCH;
          tcnt_nxt = 24'h000000;
          tmo_nxt = 1'b0;
        end else if (wr_pll) begin
          bs_nxt = dgb_pkg::BS_IDLE; // R5
        end
      end
      dgb_pkg::BS_SEARCH: begin
        if (wr_pll && req.wdata[dgb_pkg::BAND_LSB +: dgb_pkg::BAND_W] != dgb_pkg::BAND_AUTO) begin
          bs_nxt = dgb_pkg::BS_IDLE;
        end else if (lock_f) begin
          pll_nxt[dgb_pkg::BAND_LSB +: dgb_pkg::BAND_W] = band_f; // R2
          bs_nxt = dgb_pkg::BS_LOCKED;
        end else if (tcnt_r == 24'(LOCK_TIMEOUT_CYC - 1)) begin
          tmo_nxt = 1'b1;
          bs_nxt = dgb_pkg::BS_IDLE;
        end else begin
          tcnt_nxt = tcnt_r + 24'h000001;
        end
      end
      default: bs_nxt = dgb_pkg::BS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pll_r <= dgb_pkg::PLL_CTRL_RST;
      aux1_r <= dgb_pkg::AUX_RST;
      aux2_r <= dgb_pkg::AUX_RST;
      ga_r <= dgb_pkg::GAIN_RST;
      gb_r <= dgb_pkg::GAIN_RST;
      asf_r <= dgb_pkg::ASF_RST;
      tmo_r <= 1'b0;
      tcnt_r <= 24'h000000;
      bs_r <= dgb_pkg::BS_IDLE;
    end else begin
      pll_r <= pll_nxt;
      aux1_r <= aux1_nxt;
      aux2_r <= aux2_nxt;
      ga_r <= ga_nxt;
      gb_r <= gb_nxt;
      asf_r <= asf_nxt;
      tmo_r <= tmo_nxt;
      tcnt_r <= tcnt_nxt;
      bs_r <= bs_nxt;
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  logic lock_bit;
  assign lock_bit = lock_f && bs_r != dgb_pkg::BS_SEARCH; // R2

  always_comb begin
    rdata = 16'h0000;
    case (raddr)
      dgb_pkg::OFS_PLL_CTRL: rdata = pll_r;
      dgb_pkg::OFS_GAIN_A: rdata = {6'h00, ga_r};
      dgb_pkg::OFS_GAIN_B: rdata = {6'h00, gb_r};
      dgb_pkg::OFS_AUX_ONE: rdata = {aux1_r[15:14], 4'h0, aux1_r[9:0]};
      dgb_pkg::OFS_AUX_TWO: rdata = {aux2_r[15:14], 4'h0, aux2_r[9:0]};
      dgb_pkg::OFS_AMP_SCALE: rdata = {2'h0, asf_r};
      dgb_pkg::OFS_STATUS: begin
        rdata[dgb_pkg::STAT_LOCK_BIT] = lock_bit;
        rdata[dgb_pkg::STAT_TMO_BIT] = tmo_r;
        rdata[dgb_pkg::STAT_BUSY_BIT] = bs_r == dgb_pkg::BS_SEARCH;
      end
      default: rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // amplitude scaling about midscale
  // ----------------------------------------
  function automatic logic [DW-1:0] scale(input logic [DW-1:0] s, input logic [13:0] k);
    logic signed [31:0] mid;
    logic signed [31:0] dev;
    logic signed [31:0] prod;
    logic signed [31:0] res;
    mid = 32'(1 << (DW - 1));
    dev = $signed(32'(s)) - mid;
    prod = dev * $signed(32'(k));
    res = (prod >>> dgb_pkg::ASF_FRAC) + mid; // R9
    if (res < 0) return '0;
    if (res > 32'((1 << DW) - 1)) return '1;
    return res[DW-1:0];
  endfunction : scale

  logic [DW-1:0] sa_r, sa_nxt, sb_r, sb_nxt;

  always_comb begin
    sa_nxt = scale(SAMPLE_A, asf_r); // R8
    sb_nxt = scale(SAMPLE_B, asf_r); // R8
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sa_r <= DW'(1 << (DW - 1));
      sb_r <= DW'(1 << (DW - 1));
    end else begin
      sa_r <= sa_nxt;
      sb_r <= sb_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  function automatic dgb_pkg::dgb_aux_s aux_view(input logic [15:0] r);
    dgb_pkg::dgb_aux_s v;
    v.p_en = ~r[dgb_pkg::AUX_SIDE_BIT]; // R11
    v.n_en = r[dgb_pkg::AUX_SIDE_BIT]; // R11
    v.sink = r[dgb_pkg::AUX_SINK_BIT]; // R12
    v.mag = r[9:0]; // R10
    return v;
  endfunction : aux_view

  assign SCALED_A = sa_r;
  assign SCALED_B = sb_r;
  assign MAIN_GAIN_A = ga_r; // R7
  assign MAIN_GAIN_B = gb_r; // R7
  assign PLL_BAND = pll_r[dgb_pkg::BAND_LSB +: dgb_pkg::BAND_W];
  assign PLL_AUTO = bs_r == dgb_pkg::BS_SEARCH;
  assign PLL_LOCK = lock_bit;
  assign AUX_ONE = aux_view(aux1_r); // R10
  assign AUX_TWO = aux_view(aux2_r); // R10

endmodule : dgb_control

// >>> dgb_control_asserts.sv
// concurrent checks on the ports of dgb_control
// assumes binding into dgb_control; one clock domain
`timescale 1ns/1ns
module dgb_control_asserts #(
  parameter int unsigned DW = 16
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CS_N,
  input wire logic PLL_LOCK_IN,
  input wire logic PLL_AUTO,
  input wire logic PLL_LOCK,
  input wire logic SDO_OE,
  input wire logic [DW-1:0] SAMPLE_A,
  input wire logic [DW-1:0] SAMPLE_B,
  input wire logic [DW-1:0] SCALED_A,
  input wire logic [DW-1:0] SCALED_B,
  input wire logic [9:0] MAIN_GAIN_A,
  input wire logic [9:0] MAIN_GAIN_B,
  input wire dgb_pkg::dgb_aux_s AUX_ONE,
  input wire dgb_pkg::dgb_aux_s AUX_TWO
);
  localparam logic [DW-1:0] MID = {1'b1, {(DW-1){1'b0}}};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  property p_aux_one_side;
    AUX_ONE.p_en != AUX_ONE.n_en;
  endproperty
  a_aux_one_side: assert property (p_aux_one_side) else $error("aux one drives both or no side");
  property p_aux_two_side;
    AUX_TWO.p_en != AUX_TWO.n_en;
  endproperty
  a_aux_two_side: assert property (p_aux_two_side) else $error("aux two drives both or no side");
  property p_mid_a;
    SAMPLE_A == MID |=> SCALED_A == MID;
  endproperty
  a_mid_a: assert property (p_mid_a) else $error("midscale moved on channel a");
  property p_mid_b;
    SAMPLE_B == MID |=> SCALED_B == MID;
  endproperty
  a_mid_b: assert property (p_mid_b) else $error("midscale moved on channel b");
  property p_no_lock_in_search;
    PLL_AUTO |-> !PLL_LOCK;
  endproperty
  a_no_lock_in_search: assert property (p_no_lock_in_search) else $error("lock shown while searching");
  property p_lock_follows;
    (PLL_LOCK_IN && !PLL_AUTO) [*8] |-> PLL_LOCK;
  endproperty
  a_lock_follows: assert property (p_lock_follows) else $error("lock indicator missing");
  property p_gain_a_by_frame;
    $changed(MAIN_GAIN_A) |-> $past(CS_N, 3) == 1'b0;
  endproperty
  a_gain_a_by_frame: assert property (p_gain_a_by_frame) else $error("gain a changed outside a frame");
  property p_gain_b_by_frame;
    $changed(MAIN_GAIN_B) |-> $past(CS_N, 3) == 1'b0 && !SDO_OE;
  endproperty
  a_gain_b_by_frame: assert property (p_gain_b_by_frame) else $error("gain b changed outside a write");

  c_lock: cover property ($rose(PLL_LOCK));
  c_read: cover property ($rose(SDO_OE));
  c_sink: cover property (AUX_ONE.sink && AUX_ONE.n_en);
endmodule : dgb_control_asserts

// >>> dgb_control_tb.sv
// self-checking bench for dgb_control with a serial host model
// assumes a shortened lock timeout of 64 cycles
`timescale 1ns/1ns
module dgb_control_tb;
  logic CLK_SYS, ARST_N, SCLK, CS_N, SDI, SDO, SDO_OE, PLL_LOCK_IN, PLL_AUTO, PLL_LOCK;
  logic [5:0] AUTO_BAND, PLL_BAND, stored;
  logic [15:0] SAMPLE_A, SAMPLE_B, SCALED_A, SCALED_B, res_d, e, s;
  logic [9:0] MAIN_GAIN_A, MAIN_GAIN_B, g, m;
  logic [13:0] f;
  logic res_v;
  dgb_pkg::dgb_aux_s AUX_ONE, AUX_TWO;
  logic [15:0] exp_q[$];
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int temps[3] = '{-20, -35, 70};
  logic [5:0] bands[3] = '{6'd20, 6'd62, 6'd40};
  logic [5:0] expb[3] = '{6'd22, 6'd62, 6'd39};

  dgb_control #(.LOCK_TIMEOUT_CYC(64)) dut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SCLK(SCLK), .CS_N(CS_N),
    .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE), .PLL_LOCK_IN(PLL_LOCK_IN), .AUTO_BAND(AUTO_BAND),
    .PLL_BAND(PLL_BAND), .PLL_AUTO(PLL_AUTO), .PLL_LOCK(PLL_LOCK), .SAMPLE_A(SAMPLE_A), .SAMPLE_B(SAMPLE_B),
    .SCALED_A(SCALED_A), .SCALED_B(SCALED_B), .MAIN_GAIN_A(MAIN_GAIN_A), .MAIN_GAIN_B(MAIN_GAIN_B),
    .AUX_ONE(AUX_ONE), .AUX_TWO(AUX_TWO));
  dgb_host_model host (.clk(CLK_SYS), .sdo(SDO), .sclk(SCLK), .cs_n(CS_N), .sdi(SDI));

  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // note the expectation, then show the result to the watcher
  task automatic chk(input logic [15:0] ex, input logic [15:0] act);
    exp_q.push_back(ex);
    @(negedge CLK_SYS);
    res_d = act;
    res_v = 1'b1;
    @(negedge CLK_SYS);
    res_v = 1'b0;
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] r;
    host.xfer({3'b000, a}, d, r);
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [15:0] ex);
    logic [15:0] r;
    host.xfer({3'b100, a}, 16'h0000, r);
    chk(ex, r);
  endtask : rdchk

  function automatic logic [15:0] scale_ref(input logic [15:0] sv, input logic [13:0] fv);
    longint p;
    p = (((longint'(sv) - 32768) * longint'(fv)) >>> 13) + 32768;
    if (p < 0) p = 0;
    if (p > 65535) p = 65535;
    return p[15:0];
  endfunction : scale_ref

  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (res_v === 1'b1) begin
      compares++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
      if (res_d !== e) begin
        failures++;
        $display("FAIL %0t got %h expected %h", $time, res_d, e);
      end
    end
    if (cyc == 60000) begin
      failures++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end

  initial begin
    ARST_N = 1'b0;
    PLL_LOCK_IN = 1'b0;
    AUTO_BAND = 6'h00;
    SAMPLE_A = 16'h8000;
    SAMPLE_B = 16'h8000;
    res_v = 1'b0;
    res_d = 16'h0000;
    void'($urandom(32'h08179f39));
    repeat (5) @(negedge CLK_SYS);
    ARST_N = 1'b1;
    repeat (4) @(negedge CLK_SYS);
    rdchk(dgb_pkg::OFS_GAIN_A, 16'h0200);
    rdchk(dgb_pkg::OFS_AMP_SCALE, 16'h2000);
    rdchk(5'h1F, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      g = 10'($urandom);
      wr(dgb_pkg::OFS_GAIN_A, {6'h00, g});
      wr(dgb_pkg::OFS_GAIN_B, {6'h00, ~g});
      chk({6'h00, g}, {6'h00, MAIN_GAIN_A});
      chk({6'h00, ~g}, {6'h00, MAIN_GAIN_B});
      rdchk(dgb_pkg::OFS_GAIN_B, {6'h00, ~g});
    end
    for (int k = 0; k < 4; k++) begin
      m = 10'($urandom);
      wr(dgb_pkg::OFS_AUX_ONE, {k[1], k[0], 4'hF, m});
      rdchk(dgb_pkg::OFS_AUX_ONE, {k[1], k[0], 4'h0, m});
      wr(dgb_pkg::OFS_AUX_TWO, {k[0], k[1], 4'h0, ~m});
      chk({3'h0, ~k[1], k[1], k[0], m}, {3'h0, AUX_ONE});
      chk({3'h0, ~k[0], k[0], k[1], ~m}, {3'h0, AUX_TWO});
    end
    for (int k = 0; k < 6; k++) begin
      f = (k == 0) ? 14'h2000 : (k == 1) ? 14'h3FFF : (k == 2) ? 14'h0000 : 14'($urandom);
      s = 16'($urandom);
      wr(dgb_pkg::OFS_AMP_SCALE, {2'b00, f});
      SAMPLE_A = s;
      repeat (3) @(negedge CLK_SYS);
      chk(scale_ref(s, f), SCALED_A);
      chk(16'h8000, SCALED_B);
    end
    for (int k = 0; k < 3; k++) begin
      PLL_LOCK_IN = 1'b0;
      repeat (8) @(negedge CLK_SYS);
      wr(dgb_pkg::OFS_PLL_CTRL, 16'h00FC);
      chk(16'h0001, {15'h0000, PLL_AUTO});
      AUTO_BAND = bands[k];
      repeat (2) @(negedge CLK_SYS);
      PLL_LOCK_IN = 1'b1;
      host.finish_cal(temps[k], stored);
      chk({10'h000, expb[k]}, {10'h000, PLL_BAND});
      rdchk(dgb_pkg::OFS_STATUS, 16'h0008);
    end
    PLL_LOCK_IN = 1'b0;
    repeat (8) @(negedge CLK_SYS);
    wr(dgb_pkg::OFS_PLL_CTRL, 16'h00FC);
    repeat (100) @(negedge CLK_SYS);
    rdchk(dgb_pkg::OFS_STATUS, 16'h0010);
    ARST_N = 1'b0;
    repeat (5) @(negedge CLK_SYS);
    ARST_N = 1'b1;
    repeat (4) @(negedge CLK_SYS);
    chk(16'h0200, {6'h00, MAIN_GAIN_A});
    wr(dgb_pkg::OFS_PLL_CTRL, {8'h00, stored, 2'b00});
    chk({10'h000, stored}, {10'h000, PLL_BAND});
    report_and_stop();
  end
endmodule : dgb_control_tb

bind dgb_control dgb_control_asserts #(.DW(DW)) u_chk (.CLK_SYS, .ARST_N, .CS_N, .PLL_LOCK_IN, .PLL_AUTO,
  .PLL_LOCK, .SDO_OE, .SAMPLE_A, .SAMPLE_B, .SCALED_A, .SCALED_B, .MAIN_GAIN_A, .MAIN_GAIN_B, .AUX_ONE, .AUX_TWO);

// >>> dgb_host_model.sv
// host controller on the serial port: frames, band calibration
// assumes SCLK phases of 8 system cycles, pins changed at falling clock
`timescale 1ns/1ns
module dgb_host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // one 24-bit frame; read data taken at SCLK rise
  task automatic xfer(input logic [7:0] ins, input logic [15:0] wd, output logic [15:0] rd);
    logic [23:0] sh;
    sh = {ins, wd};
    rd = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      sdi = sh[23-i];
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      if (i >= 8) rd = {rd[14:0], sdo};
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (8) @(negedge clk);
  endtask : xfer

  function automatic logic [5:0] correct(input logic [5:0] b, input int t);
    int o;
    if (b < 6'h20) o = (t < -10) ? 2 : (t < 15) ? 1 : (t <= 55) ? 0 : -1;
    else o = (t < -30) ? 3 : (t < -10) ? 2 : (t < 15) ? 1 : (t <= 55) ? 0 : -1;
    o = o + int'(b);
    if (o < 0) o = 0;
    if (o > 62) o = 62;
    return o[5:0];
  endfunction : correct

  // after the search was started: wait lock, read band, write corrected band
  task automatic finish_cal(input int temp, output logic [5:0] band);
    logic [15:0] r;
    int n;
    r = 16'h0000;
    n = 0;
    while (r[3] !== 1'b1 && n < 20) begin
      xfer(8'h89, 16'h0000, r);
      n++;
    end
    xfer(8'h84, 16'h0000, r);
    band = correct(r[7:2], temp);
    xfer(8'h04, {8'h00, band, 2'b00}, r);
  endtask : finish_cal
endmodule : dgb_host_model

// >>> dgb_pkg.sv
// shared constants, types and helpers of the gain and band control block
// assumes one system clock at 10 MHz and an asynchronous active-low reset
package dgb_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned LOCK_TIME_US = 5000;
  localparam int unsigned LOCK_CYC = LOCK_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_PLL_CTRL = 5'h04;
  localparam logic [4:0] OFS_GAIN_A = 5'h05;
  localparam logic [4:0] OFS_AUX_ONE = 5'h06;
  localparam logic [4:0] OFS_GAIN_B = 5'h07;
  localparam logic [4:0] OFS_AUX_TWO = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h09;
  localparam logic [4:0] OFS_AMP_SCALE = 5'h0C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned BAND_LSB = 2;
  localparam int unsigned BAND_W = 6;
  localparam logic [5:0] BAND_AUTO = 6'h3F;
  localparam int unsigned GAIN_W = 10;
  localparam int unsigned AUX_SIDE_BIT = 15;
  localparam int unsigned AUX_SINK_BIT = 14;
  localparam int unsigned STAT_LOCK_BIT = 3;
  localparam int unsigned STAT_TMO_BIT = 4;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned ASF_W = 14;
  localparam int unsigned ASF_FRAC = 13;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] PLL_CTRL_RST = 16'h0000;
  localparam logic [9:0] GAIN_RST = 10'h200;
  localparam logic [15:0] AUX_RST = 16'h0000;
  localparam logic [13:0] ASF_RST = 14'h2000;

  // ----------------------------------------
  // serial port framing
  // ----------------------------------------
  localparam int unsigned INSTR_BITS = 8;
  localparam int unsigned DATA_BITS = 16;
  localparam int unsigned READ_BIT = 7;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } dgb_req_s;

  typedef struct packed {
    logic p_en;
    logic n_en;
    logic sink;
    logic [9:0] mag;
  } dgb_aux_s;

  typedef enum logic [2:0] {
    BS_IDLE = 3'b001,
    BS_SEARCH = 3'b010,
    BS_LOCKED = 3'b100
  } dgb_band_e;

  // a pin change counts once the second and third stages agree
  function automatic logic [15:0] sync_filt(input logic [15:0] f, input logic [15:0] s2, input logic [15:0] s3);
    logic [15:0] agree;
    agree = ~(s2 ^ s3);
    return (agree & s3) | (~agree & f);
  endfunction : sync_filt

endpackage : dgb_pkg

// >>> dgb_spi_port.sv
// serial peripheral port slave: 8-bit instruction, then 16 data bits MSB first
// assumes SCLK is slow against CLK_SYS: each SCLK phase lasts at least 6 system cycles
`timescale 1ns/1ns
module dgb_spi_port (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic sdi_pin,
  input wire logic [15:0] rdata,
  output logic sdo,
  output logic sdo_oe,
  output dgb_pkg::dgb_req_s req,
  output logic [4:0] raddr
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] s1_r, s2_r, s3_r, f_r, f_nxt;
  logic [15:0] filt;

  always_comb begin
    filt = dgb_pkg::sync_filt({13'h0000, f_r}, {13'h0000, s2_r}, {13'h0000, s3_r});
    f_nxt = filt[2:0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 3'h6;
      s2_r <= 3'h6;
      s3_r <= 3'h6;
      f_r <= 3'h6;
    end else begin
      s1_r <= {sclk_pin, cs_n_pin, sdi_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
    end
  end

  logic sclk_f, cs_n_f, sdi_f, sclk_d_r;
  assign sclk_f = f_r[2];
  assign cs_n_f = f_r[1];
  assign sdi_f = f_r[0];

  // ----------------------------------------
  // framing
  // ----------------------------------------
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] ins_r, ins_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic load_r, load_nxt, oe_r, oe_nxt;
  dgb_pkg::dgb_req_s req_r, req_nxt;
  logic rise, fall, is_rd;

  assign rise = sclk_f & ~sclk_d_r;
  assign fall = ~sclk_f & sclk_d_r;
  assign is_rd = ins_r[dgb_pkg::READ_BIT];

  always_comb begin
    cnt_nxt = cnt_r;
    ins_nxt = ins_r;
    sh_nxt = sh_r;
    load_nxt = 1'b0;
    oe_nxt = oe_r;
    req_nxt = '0;
    req_nxt.addr = ins_r[4:0];
    req_nxt.wdata = sh_r;
    if (cs_n_f) begin
      cnt_nxt = 5'h00;
      oe_nxt = 1'b0;
    end else if (load_r) begin
      if (is_rd) begin
        sh_nxt = rdata;
        oe_nxt = 1'b1;
      end
    end else if (rise && cnt_r < 5'(dgb_pkg::INSTR_BITS + dgb_pkg::DATA_BITS)) begin
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r < 5'(dgb_pkg::INSTR_BITS)) begin
        ins_nxt = {ins_r[6:0], sdi_f};
        load_nxt = (cnt_r == 5'(dgb_pkg::INSTR_BITS - 1));
      end else if (!is_rd) begin
        sh_nxt = {sh_r[14:0], sdi_f};
        if (cnt_r == 5'(dgb_pkg::INSTR_BITS + dgb_pkg::DATA_BITS - 1)) begin
          req_nxt.wr = 1'b1;
          req_nxt.wdata = {sh_r[14:0], sdi_f};
        end
      end
    end else if (fall && oe_r && cnt_r > 5'(dgb_pkg::INSTR_BITS)) begin
      sh_nxt = {sh_r[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_r <= 1'b1;
      cnt_r <= 5'h00;
      ins_r <= 8'h00;
      sh_r <= 16'h0000;
      load_r <= 1'b0;
      oe_r <= 1'b0;
      req_r <= '0;
    end else begin
      sclk_d_r <= sclk_f;
      cnt_r <= cnt_nxt;
      ins_r <= ins_nxt;
      sh_r <= sh_nxt;
      load_r <= load_nxt;
      oe_r <= oe_nxt;
      req_r <= req_nxt;
    end
  end

  assign sdo = sh_r[15];
  assign sdo_oe = oe_r;
  assign req = req_r;
  assign raddr = ins_r[4:0];

endmodule : dgb_spi_port
